// ===== core/fgor_pkg.sv
// Package for the fuel gauge output register bank.
// Assumes one 25 MHz system clock and 8-bit register offsets.
package fgor_pkg;
  localparam int          FGOR_CLK_HZ        = 25000000;
  localparam logic [7:0]  FGOR_OFF_REP_CAP   = 8'h05;
  localparam logic [7:0]  FGOR_OFF_REP_PCT   = 8'h06;
  localparam logic [7:0]  FGOR_OFF_MIX_PCT   = 8'h0D;
  localparam logic [7:0]  FGOR_OFF_AV_PCT    = 8'h0E;
  localparam logic [7:0]  FGOR_OFF_MIX_CAP   = 8'h0F;
  localparam logic [7:0]  FGOR_OFF_TTE       = 8'h11;
  localparam logic [7:0]  FGOR_OFF_AV_CAP    = 8'h1F;
  localparam logic [7:0]  FGOR_OFF_VF_PCT    = 8'hFF;
  localparam logic [15:0] FGOR_RESET_VALUE   = 16'h0000;
  localparam logic [15:0] FGOR_IDLE_CURRENT  = 16'h0006;
  localparam logic [15:0] FGOR_TTE_MAX       = 16'hFFFF;
  localparam int          FGOR_TTE_LSB_MS    = 5625;
  localparam int          FGOR_FILTER_SHIFT  = 4;
  localparam int          FGOR_NUM_REGS      = 8;
  typedef enum logic [1:0] {FGOR_DIV_IDLE, FGOR_DIV_RUN, FGOR_DIV_DONE} fgor_div_state_t;
endpackage

// ===== core/fgor_divider.sv
// Serial unsigned divider used for the time-to-empty estimate.
// Assumes operands stay stable while busy is high.
`timescale 1ns/1ps
module fgor_divider
  import fgor_pkg::*;
#(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Request
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] dividend,
  input  wire logic [WIDTH-1:0] divisor,
  // Answer
  output logic                  done,
  output logic [WIDTH-1:0]      quotient
);
  fgor_div_state_t             state;
  logic [WIDTH-1:0]            rem;
  logic [WIDTH-1:0]            quo;
  logic [$clog2(WIDTH+1)-1:0]  count;
  logic [WIDTH:0]              trial;

  assign trial = {rem, quo[WIDTH-1]} - {1'b0, divisor};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state    <= FGOR_DIV_IDLE;
      rem      <= '0;
      quo      <= '0;
      count    <= '0;
      done     <= 1'b0;
      quotient <= '0;
    end else begin
      done <= 1'b0;
      case (state)
        FGOR_DIV_IDLE: begin
          if (start) begin
            rem   <= '0;
            quo   <= dividend;
            count <= '0;
            state <= FGOR_DIV_RUN;
          end
        end
        FGOR_DIV_RUN: begin
          // Restoring division, one quotient bit per clock.
          if (!trial[WIDTH]) begin
            rem <= trial[WIDTH-1:0];
            quo <= {quo[WIDTH-2:0], 1'b1};
          end else begin
            rem <= {rem[WIDTH-2:0], quo[WIDTH-1]};
            quo <= {quo[WIDTH-2:0], 1'b0};
          end
          count <= count + 1'b1;
          if (count == ($clog2(WIDTH+1))'(WIDTH - 1)) begin
            state <= FGOR_DIV_DONE;
          end
        end
        FGOR_DIV_DONE: begin
          quotient <= quo;
          done     <= 1'b1;
          state    <= FGOR_DIV_IDLE;
        end
        default: begin
          state <= FGOR_DIV_IDLE;
        end
      endcase
    end
  end
endmodule // fgor_divider

// ===== core/fgor_regs.sv
// Read-only result register bank of the battery gauge.
// Assumes the gauging algorithm drives results on this clock with a one-cycle update strobe.
`timescale 1ns/1ps
// Functional notes
// - Offset 0Dh reads blended charge percent before empty compensation, 1/256 % steps.
// - Upper byte of each percent register is whole percent.
// - Offset 0Fh reads blended remaining capacity before empty compensation.
// - Capacities are in microvolt-hours; no division by sense resistance here.
// - Offset 06h reads a smoothed copy of compensated charge percent.
// - Offset 05h reads smoothed compensated capacity, frozen while current magnitude below 6.
// - Idle charge still lands in blended capacity, reported catches up gradually later.
// - Offset 0Eh reads unfiltered compensated charge percent, may jump.
// - Offset 1Fh reads unfiltered compensated capacity, may jump.
// - Offset FFh reads voltage-only charge percent.
// - Offset 11h reads compensated capacity over averaged current, 5.625 s steps.
module fgor_regs
  import fgor_pkg::*;
#(
  parameter int CAP_UNITS_PER_LSB_TICK = 1
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  // Algorithm results
  input  wire logic        result_valid,
  input  wire logic [15:0] blended_charge_in,
  input  wire logic [15:0] blended_capacity_in,
  input  wire logic [15:0] compensated_charge_in,
  input  wire logic [15:0] compensated_capacity_in,
  input  wire logic [15:0] voltage_only_charge_in,
  input  wire logic [15:0] averaged_cell_current,
  // Register port from the serial bus engine
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic [15:0]      reg_rdata,
  output logic             reg_rvalid,
  output logic             reg_hit
);
  logic        rst_meta;
  logic        rst_n;
  logic [15:0] blended_charge_pct;
  logic [15:0] blended_capacity;
  logic [15:0] compensated_charge_pct;
  logic [15:0] compensated_capacity;
  logic [15:0] voltage_only_charge_pct;
  logic [15:0] reported_charge_pct;
  logic [15:0] reported_capacity;
  logic [15:0] time_until_depleted;
  logic [15:0] current_mag;
  logic        current_idle;
  logic        current_discharge;
  logic [15:0] next_reported_charge;
  logic [15:0] next_reported_capacity;
  logic        div_start;
  logic        div_done;
  logic [31:0] div_quotient;
  logic [31:0] tte_dividend;
  logic [31:0] tte_divisor;
  logic [15:0] cap_hold;
  logic [15:0] cur_hold;
  logic        div_busy;
  logic        dis_hold;
  logic        div_pending;
  logic [15:0] read_mux;
  logic        read_hit;

  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Unfiltered results captured on each algorithm update.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blended_charge_pct      <= FGOR_RESET_VALUE;
      blended_capacity        <= FGOR_RESET_VALUE;
      compensated_charge_pct  <= FGOR_RESET_VALUE;
      compensated_capacity    <= FGOR_RESET_VALUE;
      voltage_only_charge_pct <= FGOR_RESET_VALUE;
    end else if (result_valid) begin
      blended_charge_pct      <= blended_charge_in;
      blended_capacity        <= blended_capacity_in;
      compensated_charge_pct  <= compensated_charge_in;
      compensated_capacity    <= compensated_capacity_in;
      voltage_only_charge_pct <= voltage_only_charge_in;
    end
  end

  // Current is two's complement; idle means magnitude below six counts.
  assign current_discharge = averaged_cell_current[15];
  assign current_mag       = current_discharge ? (16'h0000 - averaged_cell_current)
                                               : averaged_cell_current;
  assign current_idle      = (current_mag < FGOR_IDLE_CURRENT);

  // Smoothing moves a fraction of the gap per update so load steps do not show as jumps.
  function automatic logic [15:0] fgor_smooth(input logic [15:0] cur, input logic [15:0] tgt);
    logic [15:0] step;
    step = 16'h0000;
    if (tgt > cur) begin
      step = (tgt - cur) >> FGOR_FILTER_SHIFT;
      if (step == 16'h0000) begin
        step = 16'h0001;
      end
      fgor_smooth = cur + step;
    end else if (tgt < cur) begin
      step = (cur - tgt) >> FGOR_FILTER_SHIFT;
      if (step == 16'h0000) begin
        step = 16'h0001;
      end
      fgor_smooth = cur - step;
    end else begin
      fgor_smooth = cur;
    end
  endfunction

  assign next_reported_charge   = fgor_smooth(reported_charge_pct, compensated_charge_in);
  assign next_reported_capacity = fgor_smooth(reported_capacity, compensated_capacity_in);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reported_charge_pct <= FGOR_RESET_VALUE;
    end else if (result_valid) begin
      reported_charge_pct <= next_reported_charge;
    end
  end

  // Reported capacity freezes at idle and closes the gap once current flows.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reported_capacity <= FGOR_RESET_VALUE;
    end else if (result_valid && !current_idle) begin
      reported_capacity <= next_reported_capacity;
    end
  end

  // Time to empty: capacity (uVh) scaled to 5.625 s units over discharge current.
  assign div_start    = result_valid && !div_busy;
  assign tte_dividend = 32'(cap_hold) * 32'(CAP_UNITS_PER_LSB_TICK) * 32'h280;
  assign tte_divisor  = {16'h0000, cur_hold};

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_hold <= FGOR_RESET_VALUE;
      cur_hold <= FGOR_RESET_VALUE;
      dis_hold <= 1'b0;
      div_busy <= 1'b0;
    end else if (div_start) begin
      cap_hold <= compensated_capacity_in;
      cur_hold <= current_mag;
      dis_hold <= current_discharge;
      div_busy <= 1'b1;
    end else if (div_done) begin
      div_busy <= 1'b0;
    end
  end

  fgor_divider #(
    .WIDTH    (32)
  ) fgor_divider_i (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .start    (div_busy && !div_done && div_pending),
    .dividend (tte_dividend),
    .divisor  (tte_divisor),
    .done     (div_done),
    .quotient (div_quotient)
  );

  // One launch per captured operand set, a cycle after capture.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_pending <= 1'b0;
    end else begin
      div_pending <= div_start;
    end
  end

  // No discharge means no finite estimate, so the register saturates.
  // The sign is taken with the operands so a later current change cannot skew the result.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      time_until_depleted <= FGOR_TTE_MAX;
    end else if (div_done) begin
      if (!dis_hold || cur_hold == 16'h0000 || div_quotient[31:16] != 16'h0000) begin
        time_until_depleted <= FGOR_TTE_MAX;
      end else begin
        time_until_depleted <= div_quotient[15:0];
      end
    end
  end

  // Read decode; whole 16-bit word, upper byte of each percent register is whole percent.
  always_comb begin
    read_hit = 1'b1;
    case (reg_addr)
      FGOR_OFF_REP_CAP: read_mux = reported_capacity;
      FGOR_OFF_REP_PCT: read_mux = reported_charge_pct;
      FGOR_OFF_MIX_PCT: read_mux = blended_charge_pct;
      FGOR_OFF_AV_PCT:  read_mux = compensated_charge_pct;
      FGOR_OFF_MIX_CAP: read_mux = blended_capacity;
      FGOR_OFF_TTE:     read_mux = time_until_depleted;
      FGOR_OFF_AV_CAP:  read_mux = compensated_capacity;
      FGOR_OFF_VF_PCT:  read_mux = voltage_only_charge_pct;
      default: begin
        read_mux = 16'h0000;
        read_hit = 1'b0;
      end
    endcase
  end

  // Writes (reg_wr, reg_wdata) change nothing; they only report a hit.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
      reg_hit    <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      reg_hit    <= (reg_rd || reg_wr) && read_hit;
      if (reg_rd) begin
        reg_rdata <= read_mux;
      end
    end
  end
endmodule // fgor_regs

// ===== sim/fgor_asserts.sv
// Checker for the gauge result register bank, bound to its top module.
// Assumes one clock domain and the register port timing of the bank.
`timescale 1ns/1ps
module fgor_asserts
  import fgor_pkg::*;
#(
  parameter int CAP_UNITS_PER_LSB_TICK = 1
) (
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // Algorithm results
  input wire logic        result_valid,
  input wire logic [15:0] blended_charge_in,
  input wire logic [15:0] blended_capacity_in,
  input wire logic [15:0] compensated_charge_in,
  input wire logic [15:0] compensated_capacity_in,
  input wire logic [15:0] voltage_only_charge_in,
  input wire logic [15:0] averaged_cell_current,
  // Register port
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        reg_hit
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic mapped;
  assign mapped = reg_addr inside {FGOR_OFF_REP_CAP, FGOR_OFF_REP_PCT, FGOR_OFF_MIX_PCT,
    FGOR_OFF_AV_PCT, FGOR_OFF_MIX_CAP, FGOR_OFF_TTE, FGOR_OFF_AV_CAP, FGOR_OFF_VF_PCT};
  AST_READ_ANSWER: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered in the next cycle");
  AST_ANSWER_CAUSE: assert property (reg_rvalid |-> $past(reg_rd || reg_wr))
    else $error("answer without a request");
  AST_HIT_MAPPED: assert property (reg_rd && mapped |=> reg_hit)
    else $error("mapped offset not hit");
  AST_MISS_UNMAPPED: assert property (reg_rd && !mapped |=> !reg_hit && reg_rdata == 16'h0000)
    else $error("unmapped offset not refused");
  AST_WRITE_HIT: assert property (reg_wr && !reg_rd && mapped |=> reg_hit && !reg_rvalid)
    else $error("write to a mapped offset not flagged as a hit without data");
  AST_DATA_STANDS: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_RESET_QUIET: assert property ($rose(reset_n) |-> (!reg_rvalid && !reg_hit)[*2])
    else $error("outputs active right after reset");
  AST_BLEND_PCT: assert property (result_valid ##1 !result_valid ##1 (reg_rd && !result_valid
    && reg_addr == FGOR_OFF_MIX_PCT) |=> reg_rdata == $past(blended_charge_in, 3))
    else $error("blended percent not the captured value");
  AST_COMP_CAP: assert property (result_valid ##1 !result_valid ##1 (reg_rd && !result_valid
    && reg_addr == FGOR_OFF_AV_CAP) |=> reg_rdata == $past(compensated_capacity_in, 3))
    else $error("compensated capacity not the captured value");
endmodule // fgor_asserts

bind fgor_regs fgor_asserts #(.CAP_UNITS_PER_LSB_TICK(CAP_UNITS_PER_LSB_TICK)) fgor_asserts_i (
  .clk_sys, .reset_n, .result_valid, .blended_charge_in, .blended_capacity_in,
  .compensated_charge_in, .compensated_capacity_in, .voltage_only_charge_in,
  .averaged_cell_current, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid,
  .reg_hit);

// ===== sim/fgor_host.sv
// Host model that reads and writes the bank through its register port.
// Assumes the bank's clk_sys; requests change at falling edges.
`timescale 1ns/1ps
module fgor_host (
  // Clock
  input  wire logic        clk_sys,
  // Request
  output logic             reg_rd,
  output logic             reg_wr,
  output logic [7:0]       reg_addr,
  output logic [15:0]      reg_wdata,
  // Answer
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rvalid,
  input  wire logic        reg_hit
);
  initial {reg_rd, reg_wr, reg_addr, reg_wdata} = '0;
  // Released address and data show inverted values so stale lines cannot pass.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [15:0] q, output logic h);
    @(negedge clk_sys);
    reg_rd = !wr;
    reg_wr = wr;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    q = reg_rdata;
    h = reg_hit && reg_rvalid;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
endmodule // fgor_host

// ===== sim/fuel_gauge_output_registers_tb.sv
// Self-checking bench for the gauge result register bank.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module fuel_gauge_output_registers_tb;
  import fgor_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        result_valid = 1'b0;
  logic [15:0] blended_charge_in = 16'h0000;
  logic [15:0] blended_capacity_in = 16'h0000;
  logic [15:0] compensated_charge_in = 16'h0000;
  logic [15:0] compensated_capacity_in = 16'h0000;
  logic [15:0] voltage_only_charge_in = 16'h0000;
  logic [15:0] averaged_cell_current = 16'h0000;
  logic        reg_rd, reg_wr, reg_rvalid, reg_hit, h;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, q;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  fgor_regs #(.CAP_UNITS_PER_LSB_TICK(1)) fgor_regs_i (.clk_sys, .reset_n, .result_valid,
    .blended_charge_in, .blended_capacity_in, .compensated_charge_in, .compensated_capacity_in,
    .voltage_only_charge_in, .averaged_cell_current, .reg_rd, .reg_wr, .reg_addr, .reg_wdata,
    .reg_rdata, .reg_rvalid, .reg_hit);
  fgor_host fgor_host_i (.clk_sys, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .reg_hit);

  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // Reads one offset and compares both the data and the hit flag.
  task automatic rc(input logic [7:0] a, input logic [15:0] exp, input logic hit);
    fgor_host_i.xfer(1'b0, a, 16'h0000, q, h);
    chk(q, exp);
    chk({15'h0000, h}, {15'h0000, hit});
  endtask
  task automatic pulse(input logic [15:0] cur);
    @(negedge clk_sys);
    averaged_cell_current = cur;
    result_valid = 1'b1;
    @(negedge clk_sys);
    result_valid = 1'b0;
  endtask

  task automatic t_reset;
    logic [7:0] offs [9] = '{FGOR_OFF_REP_CAP, FGOR_OFF_REP_PCT, FGOR_OFF_MIX_PCT,
      FGOR_OFF_AV_PCT, FGOR_OFF_MIX_CAP, FGOR_OFF_TTE, FGOR_OFF_AV_CAP, FGOR_OFF_VF_PCT, 8'h00};
    foreach (offs[i]) begin
      rc(offs[i], offs[i] == FGOR_OFF_TTE ? FGOR_TTE_MAX : 16'h0000, i < 8);
    end
    $display("test reset_values done");
  endtask
  task automatic t_raw;
    blended_charge_in = 16'h4A80;
    blended_capacity_in = 16'h1234;
    compensated_charge_in = 16'h3C00;
    compensated_capacity_in = 16'h0800;
    voltage_only_charge_in = 16'h5B40;
    pulse(16'h0000);
    rc(FGOR_OFF_MIX_PCT, 16'h4A80, 1'b1);
    chk({8'h00, q[15:8]}, 16'h004A);
    rc(FGOR_OFF_MIX_CAP, 16'h1234, 1'b1);
    rc(FGOR_OFF_AV_PCT, 16'h3C00, 1'b1);
    rc(FGOR_OFF_AV_CAP, 16'h0800, 1'b1);
    rc(FGOR_OFF_VF_PCT, 16'h5B40, 1'b1);
    rc(FGOR_OFF_REP_PCT, 16'h3C00 >> FGOR_FILTER_SHIFT, 1'b1);
    rc(FGOR_OFF_REP_CAP, 16'h0000, 1'b1);
    $display("test raw_results done");
  endtask
  task automatic t_idle;
    pulse(16'h0005);
    rc(FGOR_OFF_REP_CAP, 16'h0000, 1'b1);
    pulse(16'hFFFB);
    rc(FGOR_OFF_REP_CAP, 16'h0000, 1'b1);
    pulse(16'hFFFA);
    rc(FGOR_OFF_REP_CAP, 16'h0800 >> FGOR_FILTER_SHIFT, 1'b1);
    $display("test idle_hold done");
  endtask
  task automatic t_write;
    fgor_host_i.xfer(1'b1, FGOR_OFF_MIX_PCT, 16'hFFFF, q, h);
    fgor_host_i.xfer(1'b1, FGOR_OFF_REP_CAP, 16'hFFFF, q, h);
    rc(FGOR_OFF_MIX_PCT, 16'h4A80, 1'b1);
    rc(FGOR_OFF_REP_CAP, 16'h0080, 1'b1);
    $display("test write_ignored done");
  endtask
  task automatic t_tte;
    repeat (60) @(negedge clk_sys);
    compensated_capacity_in = 16'h0030;
    pulse(16'hFFF0);
    repeat (60) @(negedge clk_sys);
    rc(FGOR_OFF_TTE, 16'h0780, 1'b1);
    pulse(16'h0010);
    rc(FGOR_OFF_AV_CAP, 16'h0030, 1'b1);
    repeat (60) @(negedge clk_sys);
    rc(FGOR_OFF_TTE, FGOR_TTE_MAX, 1'b1);
    $display("test time_to_empty done");
  endtask

  initial begin
    repeat (2) @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_reset();
    t_raw();
    t_idle();
    t_write();
    t_tte();
    print_verdict();
  end
endmodule // fuel_gauge_output_registers_tb
